// file: hw/iscs_flags.sv
// Sticky internal state change flags, cleared by a host read
`timescale 1ns/100ps
`include "iscs_map.svh"

// REPORT_MASK picks which defined events may latch; the default reports only
// acquisition done and trigger ready. It is fixed at build time, since a
// run-time mask would need a register that the host cannot reach.
module iscs_flags #(
    parameter logic [15:0] REPORT_MASK = `ISCS_REPORT_MASK
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_acq_done,
    input wire logic i_dump_done,
    input wire logic i_local_return,
    input wire logic i_xfer_timeout,
    input wire logic i_segment_done,
    input wire logic i_store_full,
    input wire logic i_media_swap,
    input wire logic [3:0] i_trace_done,
    input wire logic i_pass_fail_hit,
    input wire logic i_trig_ready,
    input wire logic i_read,
    output logic [15:0] o_read_data,
    output logic o_read_valid,
    output logic [15:0] o_flags
);

    // ****************************************
    // Event collection
    // ****************************************
    iscs_pkg::iscs_flags_t events_all;
    iscs_pkg::iscs_flags_t events_kept;
    iscs_pkg::iscs_flags_t flags_r;
    iscs_pkg::iscs_flags_t flags_nxt;

    always_comb
    begin
        events_all = `ISCS_RESET;
        events_all[`ISCS_BIT_ACQ_DONE] = i_acq_done;
        events_all[`ISCS_BIT_DUMP_DONE] = i_dump_done;
        events_all[`ISCS_BIT_LOCAL] = i_local_return;
        events_all[`ISCS_BIT_XFER_TMO] = i_xfer_timeout;
        events_all[`ISCS_BIT_SEGMENT] = i_segment_done;
        events_all[`ISCS_BIT_STORE_FULL] = i_store_full;
        events_all[`ISCS_BIT_MEDIA_SWAP] = i_media_swap;
        events_all[`ISCS_BIT_TRACE_A +: `ISCS_TRACE_COUNT] = i_trace_done;
        events_all[`ISCS_BIT_PASS_FAIL] = i_pass_fail_hit;
        events_all[`ISCS_BIT_TRIG_READY] = i_trig_ready;
    end

    // Bits 5, 14 and 15 carry no event; of the defined ones only the reported ones may latch
    assign events_kept = events_all & REPORT_MASK;

    // Set wins over the clearing read so no event is lost
    iscs_pkg::iscs_flags_t flags_kept;
    assign flags_kept = i_read ? `ISCS_RESET : flags_r;
    assign flags_nxt = flags_kept | events_kept;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            flags_r <= `ISCS_RESET;
            o_read_data <= `ISCS_RESET;
            o_read_valid <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            o_read_valid <= i_read;
            // Answer from the held value, so an event in the read cycle
            // is kept for the next read instead of being cleared unseen
            if (i_read)
            begin
                o_read_data <= flags_r;
            end
        end
    end

    // Live view for the rest of the instrument; looking at it never clears
    assign o_flags = flags_r;

    // ****************************************
    // Read checks
    // ****************************************
    read_returns_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_read |=> (o_read_valid && o_read_data == $past(flags_r)))
        else $error("read did not return the held flags");

    read_clears_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && events_kept == `ISCS_RESET) |=> o_flags == `ISCS_RESET)
        else $error("flags not cleared by read");

    valid_once_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_read |=> !o_read_valid)
        else $error("read valid without a read");

    data_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_read |=> $stable(o_read_data))
        else $error("read data changed without a read");

    read_range_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_read_valid |-> (o_read_data & ~REPORT_MASK) == `ISCS_RESET)
        else $error("read returned an unreported bit");

    // Back to back reads: the second one only sees what arrived in between
    both_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_flags == (`ISCS_VAL_ACQ | `ISCS_VAL_TRIG) && i_read
            && events_kept == `ISCS_RESET) ##1 (i_read && events_kept == `ISCS_RESET)
        |=> o_read_data == `ISCS_RESET)
        else $error("repeated read did not return zero");

    coincide_keep_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && events_kept[`ISCS_BIT_TRIG_READY]) ##1 i_read
        |=> o_read_data[`ISCS_BIT_TRIG_READY])
        else $error("event lost on clearing read");

    coincide_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && events_kept != `ISCS_RESET) |=> o_flags == $past(events_kept))
        else $error("event in read cycle not kept");

    // ****************************************
    // Reported event checks
    // ****************************************
    unused_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_flags & ~REPORT_MASK) == `ISCS_RESET)
        else $error("unreported bit set");

    acq_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_acq_done |=> o_flags[`ISCS_BIT_ACQ_DONE])
        else $error("acquisition event not latched");

    acq_only_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_flags == `ISCS_RESET && events_kept == `ISCS_VAL_ACQ)
        |=> o_flags == `ISCS_VAL_ACQ)
        else $error("acquisition set a wrong bit");

    trig_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_trig_ready |=> o_flags[`ISCS_BIT_TRIG_READY])
        else $error("trigger ready not latched");

    trig_only_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_flags == `ISCS_RESET && events_kept == `ISCS_VAL_TRIG)
        |=> o_flags == `ISCS_VAL_TRIG)
        else $error("trigger ready set a wrong bit");

    both_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_read && o_flags[`ISCS_BIT_ACQ_DONE] && i_trig_ready)
        |=> (o_flags[`ISCS_BIT_ACQ_DONE] && o_flags[`ISCS_BIT_TRIG_READY]))
        else $error("events did not accumulate");

    hold_between_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_read |=> (o_flags & $past(o_flags)) == $past(o_flags))
        else $error("latched bit lost without read");

    quiet_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_flags == `ISCS_RESET && events_kept == `ISCS_RESET) |=> o_flags == `ISCS_RESET)
        else $error("flag set with no event");

    // ****************************************
    // Defined events outside the reported set
    // ****************************************
    // Each bit must follow the mask: set when enabled, clear when masked off
    pass_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_pass_fail_hit |=> o_flags[`ISCS_BIT_PASS_FAIL] == REPORT_MASK[`ISCS_BIT_PASS_FAIL])
        else $error("pass/fail bit does not follow the mask");

    trace_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        |i_trace_done |=> (o_flags[`ISCS_BIT_TRACE_A +: `ISCS_TRACE_COUNT] & $past(i_trace_done))
            == ($past(i_trace_done) & REPORT_MASK[`ISCS_BIT_TRACE_A +: `ISCS_TRACE_COUNT]))
        else $error("trace bits do not follow the mask");

    swap_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_media_swap |=> o_flags[`ISCS_BIT_MEDIA_SWAP] == REPORT_MASK[`ISCS_BIT_MEDIA_SWAP])
        else $error("media swap bit does not follow the mask");

    full_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_store_full |=> o_flags[`ISCS_BIT_STORE_FULL] == REPORT_MASK[`ISCS_BIT_STORE_FULL])
        else $error("storage full bit does not follow the mask");

    segment_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_segment_done |=> o_flags[`ISCS_BIT_SEGMENT] == REPORT_MASK[`ISCS_BIT_SEGMENT])
        else $error("segment bit does not follow the mask");

    timeout_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_xfer_timeout |=> o_flags[`ISCS_BIT_XFER_TMO] == REPORT_MASK[`ISCS_BIT_XFER_TMO])
        else $error("time-out bit does not follow the mask");

    local_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_local_return |=> o_flags[`ISCS_BIT_LOCAL] == REPORT_MASK[`ISCS_BIT_LOCAL])
        else $error("local return bit does not follow the mask");

    dump_latch_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_dump_done |=> o_flags[`ISCS_BIT_DUMP_DONE] == REPORT_MASK[`ISCS_BIT_DUMP_DONE])
        else $error("screen dump bit does not follow the mask");

    // ****************************************
    // Reset checks
    // ****************************************
    reset_zero_a: assert property (@(posedge i_clk)
        i_reset |=> (o_flags == `ISCS_RESET && !o_read_valid && o_read_data == `ISCS_RESET))
        else $error("outputs not zero after reset");

endmodule

// file: hw/iscs_map.svh
// Bit positions, widths and reset values of the state change flags register
`ifndef ISCS_MAP_SVH
`define ISCS_MAP_SVH

`define ISCS_WIDTH 16
`define ISCS_RESET 16'h0000
`define ISCS_BIT_ACQ_DONE 0
`define ISCS_BIT_DUMP_DONE 1
`define ISCS_BIT_LOCAL 2
`define ISCS_BIT_XFER_TMO 3
`define ISCS_BIT_SEGMENT 4
`define ISCS_BIT_STORE_FULL 6
`define ISCS_BIT_MEDIA_SWAP 7
`define ISCS_BIT_TRACE_A 8
`define ISCS_BIT_PASS_FAIL 12
`define ISCS_BIT_TRIG_READY 13
`define ISCS_TRACE_COUNT 4
// Bits that may ever read as one in this build: 0 and 13
`define ISCS_REPORT_MASK 16'h2001
// Read-back values of a single reported event
`define ISCS_VAL_ACQ 16'h0001
`define ISCS_VAL_TRIG 16'h2000

`endif

// file: hw/iscs_pkg.sv
// Types shared by the state change flags block
package iscs_pkg;
    typedef logic [15:0] iscs_flags_t;
endpackage

// file: tb/iscs_host.sv
// Remote host model issuing read-and-clear queries
`timescale 1ns/100ps
module iscs_host (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_valid,
    input wire logic [15:0] i_data,
    output logic o_read,
    output logic [15:0] o_data
);
    // Query follows go one cycle late, one read per cycle go is high; answer taken on the valid edge
    always @(posedge i_clk)
    begin
        o_read <= i_go;
        if (i_valid)
            o_data <= i_data;
    end
endmodule

// file: tb/test_internal_state_change_status.sv
// Self-checking bench for the state change flags register
`timescale 1ns/100ps
module test_internal_state_change_status;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic go = 1'b0;
    logic [13:0] ev = 14'h0000;
    logic rd;
    logic valid;
    logic [15:0] rdata, flags, hdata;
    int n_mismatch = 0;
    int cmp_count = 0;
    // Event bits beside the value a read should give
    logic [29:0] rows [5] = '{{14'h0001, 16'h0001}, {14'h2000, 16'h2000},
        {14'h2001, 16'h2001}, {14'h1FDE, 16'h0000}, {14'h3FDF, 16'h2001}};
    always #2 i_clk = ~i_clk;
    iscs_flags DUT (.i_clk(i_clk), .i_reset(i_reset), .i_acq_done(ev[0]),
        .i_dump_done(ev[1]), .i_local_return(ev[2]), .i_xfer_timeout(ev[3]),
        .i_segment_done(ev[4]), .i_store_full(ev[6]), .i_media_swap(ev[7]),
        .i_trace_done(ev[11:8]), .i_pass_fail_hit(ev[12]), .i_trig_ready(ev[13]),
        .i_read(rd), .o_read_data(rdata), .o_read_valid(valid), .o_flags(flags));
    iscs_host host (.i_clk(i_clk), .i_go(go), .i_valid(valid), .i_data(rdata),
        .o_read(rd), .o_data(hdata));
    task automatic report(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flags(input logic [15:0] exp);
        report("flags", flags, exp);
    endtask
    task automatic chk_read(input logic [15:0] exp);
        report("read", hdata, exp);
    endtask
    task automatic chk_valid(input logic exp);
        report("valid", {15'h0000, valid}, {15'h0000, exp});
    endtask
    task automatic pulse(input logic [13:0] e);
        @(posedge i_clk);
        ev <= e;
        @(posedge i_clk);
        ev <= 14'h0000;
    endtask
    // Events given here arrive in the cycle the read is taken
    task automatic query(input logic [13:0] e);
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        ev <= e;
        @(posedge i_clk);
        ev <= 14'h0000;
        #1 chk_valid(1'b1);
        @(posedge i_clk);
        #1 chk_valid(1'b0);
    endtask
    // Two reads in a row; events given here arrive with the first one
    task automatic query_pair(input logic [13:0] e, input logic [15:0] exp1,
        input logic [15:0] exp2);
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        ev <= e;
        @(posedge i_clk);
        go <= 1'b0;
        ev <= 14'h0000;
        @(posedge i_clk);
        #1 chk_read(exp1);
        @(posedge i_clk);
        #1 chk_read(exp2);
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #2000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        #1 chk_flags(16'h0000);
        foreach (rows[i])
        begin
            pulse(rows[i][29:16]);
            #1 chk_flags(rows[i][15:0]);
            query(14'h0000);
            chk_read(rows[i][15:0]);
        end
        query(14'h0000);
        chk_read(16'h0000);
        // Events in separate cycles must add up before the read
        pulse(14'h0001);
        pulse(14'h2000);
        #1 chk_flags(16'h2001);
        query_pair(14'h0000, 16'h2001, 16'h0000);
        pulse(14'h0001);
        query(14'h2000);
        chk_read(16'h0001);
        query(14'h0000);
        chk_read(16'h2000);
        query_pair(14'h2000, 16'h0000, 16'h2000);
        pulse(14'h2001);
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        i_reset <= 1'b0;
        #1 chk_flags(16'h0000);
        query(14'h0000);
        chk_read(16'h0000);
        complete_run();
    end
endmodule
